//--- dv/buck_voltage_control_regs_tb_top.sv
// Self-checking bench for the buck voltage control registers
module buck_voltage_control_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rst_n, wr, unl, apl, byp, hit;
    logic [7:0] addr, wd, rd_a, rdat, d;
    logic [7:0] r [2];
    logic [5:0] c [2];
    logic [5:0] code1, code2;
    logic [1:0] ll, skip, blank;
    int         n_fail = 0, checked = 0, cyc = 0, seed;
    localparam int BLANK_SIM = 20;
    bvc_host_model bvc_host_model_inst (.clk_in(clk), .wr_out(wr), .addr_out(addr),
        .data_out(wd), .unl_out(unl), .apl_out(apl), .byp_out(byp));
    bvc_regs #(.BLANK_CYCLES_P(BLANK_SIM)) bvc_regs_inst (.CORE_CLK_IN(clk), .RST_N_IN(rst_n),
        .WR_EN_IN(wr), .ADDR_IN(addr), .WDATA_IN(wd), .UNLOCK_IN(unl), .RD_ADDR_IN(rd_a),
        .RDATA_OUT(rdat), .RD_HIT_OUT(hit), .APPLY_IN(apl), .APPLY_BYPASS_IN(byp),
        .LIGHT_LOAD_IN(ll), .BUCK1_VOLTAGE_CODE_OUT(code1), .BUCK2_VOLTAGE_CODE_OUT(code2),
        .SKIP_ACTIVE_OUT(skip), .MON_BLANK_OUT(blank));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    function automatic logic [7:0] exp_rb(input logic [7:0] v);
        return v & 8'hBF;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Ceiling well above the roughly 80 cycles the run needs
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_fail++;
            results();
        end
    end
    initial
    begin
        seed = 32'h55CE;
        {rst_n, rd_a, ll} = {1'b0, 8'h16, 2'b00};
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        r = '{8'hAB, 8'hB2};
        c = '{6'h2B, 6'h32};
        chk(rdat, r[0]);
        chk(code1, c[0]);
        chk(code2, c[1]);
        rd_a = 8'h17;
        #1 chk(rdat, r[1]);
        chk(hit, 1'b1);
        rd_a = 8'h18;
        #1 chk({hit, rdat[6:0]}, 8'h00);
        bvc_host_model_inst.write(8'h16, 8'h15, 1'b0);
        rd_a = 8'h16;
        #1 chk(rdat, r[0]);
        bvc_host_model_inst.write(8'h17, 8'h00, 1'b0);
        bvc_host_model_inst.write(8'h18, 8'h00, 1'b1);
        rd_a = 8'h17;
        #1 chk(rdat, r[1]);
        chk(blank, 2'b00);
        $display("reset and lock test done");
        for (int i = 0; i < 4; i++)
        begin
            d = (i == 0) ? 8'h7F : 8'($random(seed));
            bvc_host_model_inst.write({7'h0B, i[0]}, d, 1'b1);
            r[i[0]] = exp_rb(d);
            rd_a = {7'h0B, i[0]};
            #1 chk(rdat, r[i[0]]);
            chk(blank[i[0]], 1'b1);
            chk(i[0] ? code2 : code1, c[i[0]]);
            bvc_host_model_inst.apply(i[1]);
            @(posedge clk);
            #1 c = '{r[0][5:0], r[1][5:0]};
            chk(code1, c[0]);
            chk(code2, c[1]);
        end
        $display("write and apply test done");
        repeat (25) @(posedge clk);
        #1 chk(blank, 2'b00);
        ll = 2'b11;
        repeat (4) @(posedge clk);
        #1 chk(skip, {r[1][7], r[0][7]});
        bvc_host_model_inst.write(8'h16, 8'h40, 1'b1);
        r[0] = exp_rb(8'h40);
        rd_a = 8'h16;
        repeat (BLANK_SIM - 1) @(posedge clk);
        #1 chk(blank[0], 1'b1);
        chk(skip[0], 1'b0);
        chk(rdat, r[0]);
        @(posedge clk);
        #1 chk(blank[0], 1'b0);
        $display("blank and skip test done");
        results();
    end
endmodule

//--- dv/bvc_host_model.sv
// Host side model writing the buck control registers
module bvc_host_model (
    input  wire logic       clk_in,   // Register clock
    output logic            wr_out,   // Write strobe
    output logic      [7:0] addr_out, // Subaddress
    output logic      [7:0] data_out, // Write data
    output logic            unl_out,  // Unlock granted
    output logic            apl_out,  // Apply pulse
    output logic            byp_out   // Apply bypass
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {wr_out, addr_out, data_out, unl_out, apl_out, byp_out} = '0;
    // ----------------------------------------
    // Bus cycles, released address and data lines show inverse
    // ----------------------------------------
    task automatic write(input logic [7:0] a, input logic [7:0] d, input logic u);
        @(posedge clk_in);
        #1;
        {wr_out, addr_out, data_out, unl_out} = {1'b1, a, d, u};
        @(posedge clk_in);
        #1;
        {wr_out, addr_out, data_out, unl_out} = {1'b0, ~a, ~d, 1'b0};
    endtask
    task automatic apply(input logic byp);
        @(posedge clk_in);
        #1;
        {apl_out, byp_out} = {~byp, byp};
        @(posedge clk_in);
        #1;
        {apl_out, byp_out} = 2'b00;
    endtask
endmodule

//--- shared/bvc_pkg.sv
// Shared constants for the buck voltage control register pair
package bvc_pkg;
    localparam logic [7:0] BUCK1_OFFSET    = 8'h16;
    localparam logic [7:0] BUCK2_OFFSET    = 8'h17;
    localparam logic [7:0] BUCK1_RESET     = 8'hAB;
    localparam logic [7:0] BUCK2_RESET     = 8'hB2;
    localparam int         SKIP_BIT        = 7;
    localparam int         RSVD_BIT        = 6;
    localparam int         CODE_MSB        = 5;
    localparam logic [7:0] WRITE_MASK      = 8'hBF;
    localparam int         BLANK_TIME_US   = 5000;
    localparam int         CLK_PERIOD_NS   = 10;
    localparam int         BLANK_CYCLES    = (BLANK_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int         BLANK_CNT_W     = 19;
endpackage

//--- verilog/bvc_regs.sv
// Buck converter voltage and light-load control registers
// Function
// - First buck register sits at subaddress 16h and resets to ABh.
// - Second buck register sits at subaddress 17h, resets to B2h, same layout.
// - Writes land only when the password unlock is granted; others are ignored.
// - Any accepted write blanks that output's OV/UV monitoring for 5 ms.
// - A new voltage code reaches the output only after apply or apply-bypass is set.
// - Bit 7 selects light-load mode, 0 forced PWM, 1 pulse-skip, resetting to 1.
// - Bits 5..0 hold the six-bit voltage code.
// - Second converter code resets to 32h with skip enable set and bit 6 zero.
module bvc_regs #(
    parameter int BLANK_CYCLES_P = bvc_pkg::BLANK_CYCLES
) (
    input  wire logic       CORE_CLK_IN,        // Register clock
    input  wire logic       RST_N_IN,           // Sync reset, active low
    input  wire logic       WR_EN_IN,           // Register write strobe
    input  wire logic [7:0] ADDR_IN,            // Subaddress
    input  wire logic [7:0] WDATA_IN,           // Write data
    input  wire logic       UNLOCK_IN,          // Password unlock granted
    input  wire logic [7:0] RD_ADDR_IN,         // Read subaddress
    output logic      [7:0] RDATA_OUT,          // Read data
    output logic            RD_HIT_OUT,         // Read address maps here
    input  wire logic       APPLY_IN,           // Apply bit pulse
    input  wire logic       APPLY_BYPASS_IN,    // Apply-bypass bit level
    input  wire logic [1:0] LIGHT_LOAD_IN,      // Light-load seen per converter
    output logic      [5:0] BUCK1_VOLTAGE_CODE_OUT, // Active code, converter 1
    output logic      [5:0] BUCK2_VOLTAGE_CODE_OUT, // Active code, converter 2
    output logic      [1:0] SKIP_ACTIVE_OUT,    // Pulse-skip in use
    output logic      [1:0] MON_BLANK_OUT       // OV/UV monitor blanked
);
    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    logic [7:0] buck1_r;
    logic [7:0] buck2_r;
    logic [5:0] act1_r;
    logic [5:0] act2_r;
    logic [bvc_pkg::BLANK_CNT_W-1:0] blank1_r;
    logic [bvc_pkg::BLANK_CNT_W-1:0] blank2_r;
    logic [1:0] ll1_r;
    logic [1:0] ll2_r;

    // ------------------------------------------------------------
    // Subaddress decode
    // ------------------------------------------------------------
    // Shared by the write decode, the read decode and the checks below
    function automatic logic addr_is(
        input logic [7:0] addr,
        input logic [7:0] offset
    );
        addr_is = (addr == offset);
    endfunction

    wire wr1 = WR_EN_IN && UNLOCK_IN && addr_is(ADDR_IN, bvc_pkg::BUCK1_OFFSET);
    wire wr2 = WR_EN_IN && UNLOCK_IN && addr_is(ADDR_IN, bvc_pkg::BUCK2_OFFSET);
    // Reserved bit is masked on the way in so storage can never hold a one
    wire [7:0] wval = WDATA_IN & bvc_pkg::WRITE_MASK;
    wire apply = APPLY_IN || APPLY_BYPASS_IN;

    function automatic logic [bvc_pkg::BLANK_CNT_W-1:0] blank_next(
        input logic wr,
        input logic [bvc_pkg::BLANK_CNT_W-1:0] cnt
    );
        if (wr)
            blank_next = bvc_pkg::BLANK_CNT_W'(BLANK_CYCLES_P);
        else if (cnt != '0)
            blank_next = cnt - 1'b1;
        else
            blank_next = cnt;
    endfunction

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            buck1_r  <= bvc_pkg::BUCK1_RESET;
            buck2_r  <= bvc_pkg::BUCK2_RESET;
            act1_r   <= bvc_pkg::BUCK1_RESET[5:0];
            act2_r   <= bvc_pkg::BUCK2_RESET[5:0];
            blank1_r <= '0;
            blank2_r <= '0;
            ll1_r    <= 2'h0;
            ll2_r    <= 2'h0;
        end
        else
        begin
            if (wr1)
                buck1_r <= wval;
            if (wr2)
                buck2_r <= wval;
            if (apply)
            begin
                act1_r <= buck1_r[bvc_pkg::CODE_MSB:0];
                act2_r <= buck2_r[bvc_pkg::CODE_MSB:0];
            end
            blank1_r <= blank_next(wr1, blank1_r);
            blank2_r <= blank_next(wr2, blank2_r);
            ll1_r    <= {ll1_r[0], LIGHT_LOAD_IN[0]};
            ll2_r    <= {ll2_r[0], LIGHT_LOAD_IN[1]};
        end
    end

    // ------------------------------------------------------------
    // Outputs and read path
    // ------------------------------------------------------------
    assign BUCK1_VOLTAGE_CODE_OUT = act1_r;
    assign BUCK2_VOLTAGE_CODE_OUT = act2_r;
    // Skip only where enabled and load is light; else normal switching
    assign SKIP_ACTIVE_OUT[0] = buck1_r[bvc_pkg::SKIP_BIT] && ll1_r[1];
    assign SKIP_ACTIVE_OUT[1] = buck2_r[bvc_pkg::SKIP_BIT] && ll2_r[1];
    assign MON_BLANK_OUT = {blank2_r != '0, blank1_r != '0};

    wire hit1 = addr_is(RD_ADDR_IN, bvc_pkg::BUCK1_OFFSET);
    wire hit2 = addr_is(RD_ADDR_IN, bvc_pkg::BUCK2_OFFSET);
    assign RD_HIT_OUT = hit1 || hit2;
    assign RDATA_OUT  = hit1 ? buck1_r : (hit2 ? buck2_r : 8'h00);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_wr1;
        wr1;
    endsequence

    sequence s_wr2;
        wr2;
    endsequence

    // Write to neither register, whether unlocked or not
    sequence s_foreign_wr;
        WR_EN_IN && !addr_is(ADDR_IN, bvc_pkg::BUCK1_OFFSET)
                 && !addr_is(ADDR_IN, bvc_pkg::BUCK2_OFFSET);
    endsequence

    // Three sampled light-load cycles with skip enabled on converter 2
    sequence s_light2;
        (buck2_r[bvc_pkg::SKIP_BIT] && LIGHT_LOAD_IN[1]) [*3];
    endsequence

    a_reset_values: assert property (@(posedge CORE_CLK_IN)
        !RST_N_IN |=> buck1_r == bvc_pkg::BUCK1_RESET && buck2_r == bvc_pkg::BUCK2_RESET)
        else $error("reset values wrong");
    a_locked_write: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        WR_EN_IN && !UNLOCK_IN |=> $stable(buck1_r) && $stable(buck2_r))
        else $error("locked write changed a register");
    a_blank_start: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        s_wr1 |=> MON_BLANK_OUT[0] [*8])
        else $error("blanking not raised after write");
    a_pending_hold: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        !apply |=> $stable(act1_r) && $stable(act2_r))
        else $error("active code moved without apply");
    a_apply_copy: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        apply |=> act1_r == $past(buck1_r[5:0]) && act2_r == $past(buck2_r[5:0]))
        else $error("apply did not copy code");
    a_readback: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        wr2 ##1 (RD_ADDR_IN == bvc_pkg::BUCK2_OFFSET) |-> RDATA_OUT == $past(wval))
        else $error("read-back mismatch");
    a_rsvd_zero: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        RDATA_OUT[bvc_pkg::RSVD_BIT] == 1'b0)
        else $error("reserved bit read one");
    a_skip_forced: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        !buck1_r[7] |-> !SKIP_ACTIVE_OUT[0])
        else $error("skip active while forced PWM");
    a_skip_light: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        s_light2 |-> SKIP_ACTIVE_OUT[1])
        else $error("skip not entered at light load");
    a_code_reset2: assert property (@(posedge CORE_CLK_IN)
        !RST_N_IN |=> act2_r == 6'h32)
        else $error("second code reset wrong");
    a_code_reset1: assert property (@(posedge CORE_CLK_IN)
        !RST_N_IN |=> act1_r == 6'h2B && SKIP_ACTIVE_OUT == 2'h0 && MON_BLANK_OUT == 2'h0)
        else $error("first code or outputs reset wrong");
    a_write1_lands: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        s_wr1 |=> buck1_r == $past(wval))
        else $error("first register write lost");
    a_write2_lands: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        s_wr2 |=> buck2_r == $past(wval))
        else $error("second register write lost");
    a_foreign_write: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        s_foreign_wr |=> $stable(buck1_r) && $stable(buck2_r))
        else $error("write to other address changed a register");
    a_blank2_start: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        s_wr2 |=> MON_BLANK_OUT[1] [*8])
        else $error("second blanking not raised after write");
    // Counter-based, since the full interval is far too long to unroll
    a_blank_count1: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        blank1_r != '0 && !wr1 |=> blank1_r == $past(blank1_r) - 1)
        else $error("first blanking counter skipped");
    a_blank_count2: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        blank2_r != '0 && !wr2 |=> blank2_r == $past(blank2_r) - 1)
        else $error("second blanking counter skipped");
    a_blank_idle: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        blank1_r == '0 && !wr1 |=> !MON_BLANK_OUT[0])
        else $error("blanking raised without a write");
    a_rsvd_store: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        !buck1_r[bvc_pkg::RSVD_BIT] && !buck2_r[bvc_pkg::RSVD_BIT])
        else $error("reserved bit stored as one");
    a_unmapped_read: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        !RD_HIT_OUT |-> RDATA_OUT == 8'h00)
        else $error("unmapped read returned data");
    a_skip2_forced: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        !buck2_r[7] |-> !SKIP_ACTIVE_OUT[1])
        else $error("second skip active while forced PWM");
    // Light-load pin is asynchronous, so skip must lag it by the synchroniser
    a_sync_delay: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        $rose(LIGHT_LOAD_IN[0]) |=> !SKIP_ACTIVE_OUT[0])
        else $error("skip followed light load without sync delay");
    a_bypass_copy: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        APPLY_BYPASS_IN |=> act1_r == $past(buck1_r[5:0]))
        else $error("apply-bypass did not copy code");
endmodule
